// [logic/ldc_regs.sv]
// The Avalon-MM interface to the registers was decided locally.
module ldc_regs (
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	// avalon-mm slave
	input  wire logic [4:0]        i_avs_address,
	input  wire logic              i_avs_read,
	input  wire logic              i_avs_write,
	input  wire logic [31:0]       i_avs_writedata,
	input  wire logic [3:0]        i_avs_byteenable,
	output logic      [31:0]       o_avs_readdata,
	output logic                   o_avs_waitrequest,
	// link receiver side
	input  wire ldc_pkg::ldc_frame_s i_frame,
	input  wire logic              i_channel_inactive,
	output logic                   o_ack,
	// pins
	input  wire logic              i_error_band_select,
	input  wire logic              i_loop_fault,
	// converter side
	output logic      [15:0]       o_output_code,
	output logic                   o_error_active,
	output logic                   o_unlocked
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	ldc_pkg::ldc_bus_e bus_state;
	ldc_pkg::ldc_bus_e next_bus_state;
	logic [7:0]  lock_key;
	logic [7:0]  enables;
	logic [7:0]  threshold;
	logic [7:0]  low_code;
	logic [7:0]  high_code;
	logic [15:0] dac_code;
	logic        err_state;
	logic        srst;
	logic        rst_all;
	logic [1:0]  pin_s;
	logic        band_s;
	logic        loop_s;
	logic        unlocked;
	logic        f_wr;
	logic        b_wr;
	logic        bus_req;
	logic        bus_accept;
	logic        bus_hit;
	logic [2:0]  bus_idx;
	logic        wr_en;
	logic [2:0]  wr_idx;
	logic [7:0]  wr_data;
	logic        cfg_wr;
	logic        cmd_wr;
	logic [1:0]  cmd;
	logic        trip;
	logic        set_evt;
	logic        clr_evt;
	logic        reporting;
	logic        run_err;

	function automatic logic [7:0] rd_reg(input logic [2:0] idx);
		case (idx)
			ldc_pkg::REG_LOCK: rd_reg = lock_key;
			ldc_pkg::REG_CMD:  rd_reg = {7'h00, srst};
			ldc_pkg::REG_ENA:  rd_reg = enables;
			ldc_pkg::REG_THR:  rd_reg = threshold;
			ldc_pkg::REG_LOW:  rd_reg = low_code;
			ldc_pkg::REG_HIGH: rd_reg = high_code;
			default:           rd_reg = 8'h00;
		endcase
	endfunction : rd_reg

	// ---------------------------------------------------------------
	// pins and resets
	// ---------------------------------------------------------------
	ldc_sync #(
		.W (2)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async ({i_loop_fault, i_error_band_select}),
		.o_sync  (pin_s)
	);

	assign band_s  = pin_s[0];
	assign loop_s  = pin_s[1];
	// soft reset joins power-on on rst_all; the bus slave and the pin synchronizer reset on i_rst only
	assign rst_all = i_rst || srst;

	// ---------------------------------------------------------------
	// avalon slave: one wait cycle, stalled while a frame writes
	// ---------------------------------------------------------------
	assign bus_req    = i_avs_read || i_avs_write;
	assign bus_idx    = i_avs_address[4:2];
	assign bus_hit    = (i_avs_address[1:0] == 2'b00) && (bus_idx <= ldc_pkg::REG_HIGH);
	assign f_wr       = i_frame.valid && !i_frame.is_dac;
	// link cannot be stalled, so the bus yields to it
	assign bus_accept = (bus_state == ldc_pkg::BUS_ANSWER) && !f_wr;
	assign o_avs_waitrequest = bus_req && !bus_accept;
	assign b_wr       = bus_accept && i_avs_write && i_avs_byteenable[0] && bus_hit;

	always_comb
	begin
		case (bus_state)
			ldc_pkg::BUS_IDLE:
				next_bus_state = bus_req ? ldc_pkg::BUS_ANSWER : ldc_pkg::BUS_IDLE;
			ldc_pkg::BUS_ANSWER:
				next_bus_state = bus_accept ? ldc_pkg::BUS_IDLE : ldc_pkg::BUS_ANSWER;
			default:
				next_bus_state = ldc_pkg::BUS_IDLE;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			bus_state <= ldc_pkg::BUS_IDLE;
		else
			bus_state <= next_bus_state;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_avs_readdata <= 32'h0000_0000;
		else if (bus_hit)
			o_avs_readdata <= {24'h00_0000, rd_reg(bus_idx)};
		else
			o_avs_readdata <= 32'h0000_0000;
	end

	// ---------------------------------------------------------------
	// write port: frame first, else bus
	// ---------------------------------------------------------------
	assign wr_en    = f_wr || b_wr;
	assign wr_idx   = f_wr ? i_frame.addr : bus_idx;
	assign wr_data  = f_wr ? i_frame.data[7:0] : i_avs_writedata[7:0];
	assign unlocked = (lock_key == ldc_pkg::UNLOCK_KEY);
	assign cfg_wr   = wr_en && unlocked;
	assign cmd_wr   = cfg_wr && (wr_idx == ldc_pkg::REG_CMD);
	assign cmd      = wr_data[ldc_pkg::CMD_LSB +: 2];

	always_ff @(posedge i_clk)
	begin
		if (rst_all)
			lock_key <= ldc_pkg::RST_LOCK;
		else if (wr_en && wr_idx == ldc_pkg::REG_LOCK)
			lock_key <= wr_data;
	end

	// pulse: high for one cycle, then the reset path clears it
	always_ff @(posedge i_clk)
	begin
		if (rst_all)
			srst <= 1'b0;
		else
			srst <= cmd_wr && wr_data[ldc_pkg::SRST_BIT];
	end

	// reserved bits are masked so a careless master reads them back as zero
	always_ff @(posedge i_clk)
	begin
		if (rst_all)
		begin
			enables   <= ldc_pkg::RST_ENA;
			threshold <= ldc_pkg::RST_THR;
			low_code  <= ldc_pkg::RST_LOW;
			high_code <= ldc_pkg::RST_HIGH;
		end
		else if (cfg_wr)
		begin
			case (wr_idx)
				ldc_pkg::REG_ENA:  enables   <= wr_data & ldc_pkg::ENA_MASK;
				ldc_pkg::REG_THR:  threshold <= wr_data & ldc_pkg::THR_MASK;
				ldc_pkg::REG_LOW:  low_code  <= wr_data;
				ldc_pkg::REG_HIGH: high_code <= wr_data;
				default:           threshold <= threshold;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (rst_all)
			dac_code <= ldc_pkg::RST_CODE;
		else if (i_frame.valid && i_frame.is_dac && !unlocked)
			dac_code <= i_frame.data;
	end

	// ---------------------------------------------------------------
	// error condition
	// ---------------------------------------------------------------
	assign run_err = (i_frame.frame_err && enables[ldc_pkg::ENA_FRAME])
		|| (i_frame.parity_err && enables[ldc_pkg::ENA_PAR]);

	ldc_err_run u_err_run (
		.i_clk  (i_clk),
		.i_rst  (rst_all),
		.i_err  (run_err),
		.i_good (i_frame.valid),
		.i_thr  (threshold[3:0]),
		.o_trip (trip)
	);

	assign set_evt = (cmd_wr && cmd == ldc_pkg::ERR_SET) || trip
		|| (i_channel_inactive && enables[ldc_pkg::ENA_CHAN]);
	assign clr_evt = (cmd_wr && cmd == ldc_pkg::ERR_CLR) || i_frame.valid;

	// set beats clear when both land together
	always_ff @(posedge i_clk)
	begin
		if (rst_all)
			err_state <= 1'b1;
		else if (set_evt)
			err_state <= 1'b1;
		else if (clr_evt)
			err_state <= 1'b0;
	end

	assign reporting = err_state || (loop_s && enables[ldc_pkg::ENA_LOOP]);

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (rst_all)
		begin
			o_output_code <= ldc_pkg::RST_CODE;
			o_ack         <= 1'b0;
		end
		else
		begin
			if (!reporting)
				o_output_code <= dac_code;
			else if (band_s)
				o_output_code <= {high_code, ldc_pkg::CODE_LOW_BYTE};
			else
				o_output_code <= {low_code, ldc_pkg::CODE_LOW_BYTE};
			o_ack <= i_frame.valid && enables[ldc_pkg::ENA_ACK];
		end
	end

	assign o_error_active = reporting;
	assign o_unlocked     = unlocked;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (rst_all);

	sequence s_key_write(logic [7:0] key);
		wr_en && wr_idx == ldc_pkg::REG_LOCK && wr_data == key;
	endsequence

	a_unlock_key : assert property (
		s_key_write(ldc_pkg::UNLOCK_KEY) |=> o_unlocked)
		else $error("unlock key did not unlock");

	a_lock_other : assert property (
		wr_en && wr_idx == ldc_pkg::REG_LOCK && wr_data != ldc_pkg::UNLOCK_KEY |=> !o_unlocked)
		else $error("non key value did not lock");

	a_dac_hold : assert property (
		i_frame.valid && i_frame.is_dac && unlocked |=> $stable(dac_code))
		else $error("output code changed while unlocked");

	a_cmd_set : assert property (
		cmd_wr && cmd == ldc_pkg::ERR_SET |=> err_state ##1 o_output_code[7:0] == 8'h00)
		else $error("set command did not raise the error");

	a_frame_clear : assert property (
		i_frame.valid && !set_evt |=> !err_state)
		else $error("valid frame did not clear the error");

	a_cmd_reads_zero : assert property (
		bus_accept && i_avs_read && bus_idx == ldc_pkg::REG_CMD
		|-> o_avs_readdata[4:3] == 2'b00)
		else $error("error command field read back nonzero");

	a_ack_pulse : assert property (
		i_frame.valid && enables[ldc_pkg::ENA_ACK] |=> o_ack ##1
		(o_ack == ($past(i_frame.valid) && $past(enables[ldc_pkg::ENA_ACK]))))
		else $error("acknowledge missing after valid frame");

	a_low_band : assert property (
		reporting && !band_s |=> o_output_code == {$past(low_code), 8'h00})
		else $error("low band error code wrong");

	a_high_band : assert property (
		reporting && band_s |=> o_output_code == {$past(high_code), 8'h00})
		else $error("high band error code wrong");

	a_bad_frame : assert property (
		!i_frame.valid && !b_wr |=> $stable(enables) && $stable(threshold) && $stable(low_code))
		else $error("register changed without a valid write");

endmodule : ldc_regs

// [logic/ldc_pkg.sv]
package ldc_pkg;

	// ---------------------------------------------------------------
	// register indices (byte address = 4 * index)
	// ---------------------------------------------------------------
	localparam logic [2:0] REG_LOCK = 3'h0;
	localparam logic [2:0] REG_CMD  = 3'h1;
	localparam logic [2:0] REG_ENA  = 3'h2;
	localparam logic [2:0] REG_THR  = 3'h3;
	localparam logic [2:0] REG_LOW  = 3'h4;
	localparam logic [2:0] REG_HIGH = 3'h5;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]  RST_LOCK = 8'h00;
	localparam logic [7:0]  RST_CMD  = 8'h08;
	localparam logic [7:0]  RST_ENA  = 8'h1f;
	localparam logic [7:0]  RST_THR  = 8'h08;
	localparam logic [7:0]  RST_LOW  = 8'h24;
	localparam logic [7:0]  RST_HIGH = 8'he8;
	localparam logic [15:0] RST_CODE = 16'h0000;

	// ---------------------------------------------------------------
	// fields and codes
	// ---------------------------------------------------------------
	localparam logic [7:0] UNLOCK_KEY = 8'h95;
	localparam int         CMD_LSB    = 3;
	localparam int         SRST_BIT   = 0;
	localparam int         ENA_ACK    = 4;
	localparam int         ENA_FRAME  = 3;
	localparam int         ENA_PAR    = 2;
	localparam int         ENA_CHAN   = 1;
	localparam int         ENA_LOOP   = 0;
	localparam logic [7:0] ENA_MASK   = 8'h1f;
	localparam logic [7:0] THR_MASK   = 8'h0f;
	localparam logic [1:0] ERR_SET    = 2'b01;
	localparam logic [1:0] ERR_CLR    = 2'b10;
	localparam logic [7:0] CODE_LOW_BYTE = 8'h00;

	// one decoded frame from the single-wire link receiver
	typedef struct packed {
		logic        valid;
		logic        frame_err;
		logic        parity_err;
		logic        is_dac;
		logic [2:0]  addr;
		logic [15:0] data;
	} ldc_frame_s;

	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b01,
		BUS_ANSWER = 2'b10
	} ldc_bus_e;

endpackage : ldc_pkg

// [logic/ldc_sync.sv]
module ldc_sync #(
	parameter int W = 2
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// levels
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			meta   <= '0;
			o_sync <= '0;
		end
		else
		begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end

endmodule : ldc_sync

// [logic/ldc_err_run.sv]
module ldc_err_run (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// events
	input  wire logic       i_err,
	input  wire logic       i_good,
	input  wire logic [3:0] i_thr,
	output logic            o_trip
);

	logic [4:0] run;
	logic [4:0] next_run;

	assign next_run = run + 5'h01;
	// trip when the run reaches one plus the threshold
	assign o_trip = i_err && (next_run == {1'b0, i_thr} + 5'h01);

	always_ff @(posedge i_clk)
	begin
		if (i_rst || i_good)
			run <= 5'h00;
		else if (o_trip)
			run <= 5'h00;
		else if (i_err)
			run <= next_run;
	end

	a_trip_count : assert property (@(posedge i_clk) disable iff (i_rst)
		o_trip |-> run[3:0] == i_thr)
		else $error("trip before the run reached the threshold");

endmodule : ldc_err_run

// [tb/ldc_link_model.sv]
module ldc_link_model (
	// clock
	input  wire logic          i_clk,
	// decoded frames towards the block
	output ldc_pkg::ldc_frame_s o_frame,
	output logic               o_channel_inactive
);
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// frame source
	// ---------------------------------------------------------------
	initial
	begin
		o_frame = '0;
		o_channel_inactive = 1'b0;
	end

	// one frame per call; bad frames arrive with valid low
	task automatic send(input ldc_pkg::ldc_frame_s f);
		@(posedge i_clk);
		o_frame <= f;
		@(posedge i_clk);
		// stale payload is scrambled so nothing can lean on it
		o_frame <= {7'h00, ~f.data};
	endtask : send

	// one-cycle channel-inactive event
	task automatic pulse_inactive();
		@(posedge i_clk);
		o_channel_inactive <= 1'b1;
		@(posedge i_clk);
		o_channel_inactive <= 1'b0;
	endtask : pulse_inactive

endmodule : ldc_link_model

// [tb/ldc_regs_tb.sv]
module ldc_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic                clk;
	logic                rst;
	logic [4:0]          adr;
	logic                rd;
	logic                wrt;
	logic [31:0]         wd;
	logic [31:0]         rdata;
	logic                waitreq;
	ldc_pkg::ldc_frame_s frame;
	logic                inact;
	logic                ack;
	logic                band;
	logic                loop_f;
	logic [15:0]         code;
	logic                err;
	logic                unl;
	int                  failures;
	int                  n_compared;
	logic [31:0]         q;
	logic [7:0]          lo;
	logic [7:0]          k;
	logic [15:0]         dac;
	bit                  me;
	logic [7:0]          rv [7] = '{8'h00, 8'h00, 8'h1f, 8'h08, 8'h24, 8'he8, 8'h00};
	int                  pats [5] = '{2, 0, 1, 3, 2};

	ldc_regs dut (
		.i_clk               (clk),
		.i_rst               (rst),
		.i_avs_address       (adr),
		.i_avs_read          (rd),
		.i_avs_write         (wrt),
		.i_avs_writedata     (wd),
		.i_avs_byteenable    (4'h1),
		.o_avs_readdata      (rdata),
		.o_avs_waitrequest   (waitreq),
		.i_frame             (frame),
		.i_channel_inactive  (inact),
		.o_ack               (ack),
		.i_error_band_select (band),
		.i_loop_fault        (loop_f),
		.o_output_code       (code),
		.o_error_active      (err),
		.o_unlocked          (unl)
	);

	ldc_link_model link (
		.i_clk              (clk),
		.o_frame            (frame),
		.o_channel_inactive (inact)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic finish_test();
		$display("compared %0d, mismatched %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// request held until waitrequest is sampled low at a rising edge
	task automatic bus(input bit w, input logic [2:0] i, input logic [7:0] d,
			output logic [31:0] r);
		@(posedge clk);
		adr <= {i, 2'b00};
		rd <= !w;
		wrt <= w;
		wd <= {24'h000000, d};
		do
			@(posedge clk);
		while (waitreq !== 1'b0);
		r = rdata;
		rd <= 1'b0;
		wrt <= 1'b0;
	endtask : bus

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt

	function automatic logic [15:0] ecode(bit e, bit hi, logic [7:0] l, logic [15:0] dv);
		return e ? {hi ? 8'he8 : l, 8'h00} : dv;
	endfunction : ecode

	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		finish_test();
	end

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial
	begin
		{adr, rd, wrt, wd, band, loop_f} = '0;
		rst = 1'b1;
		failures = 0;
		n_compared = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		void'($urandom(32'h46e50548));
		for (int i = 0; i < 7; i++)
		begin
			bus(0, i[2:0], 8'h00, q);
			chk(q, {24'h0, rv[i]});
		end
		chk(err, 1);
		chk(code, 16'h2400);
		bus(1, 3'h2, 8'h00, q);
		bus(0, 3'h2, 8'h00, q);
		chk(q, 32'h1f);
		bus(1, 3'h0, 8'h95, q);
		wt(1);
		chk(unl, 1);
		lo = 8'($urandom);
		bus(1, 3'h4, lo, q);
		bus(0, 3'h4, 8'h00, q);
		chk(q, {24'h0, lo});
		me = 1;
		dac = 16'h0000;
		foreach (pats[p])
		begin
			bus(1, 3'h1, {3'b000, 2'(pats[p]), 3'b000}, q);
			me = (pats[p] == 1) ? 1'b1 : (pats[p] == 2) ? 1'b0 : me;
			wt(3);
			chk(err, me);
			chk(code, ecode(me, 0, lo, dac));
			bus(0, 3'h1, 8'h00, q);
			chk(q, 0);
		end
		link.send({4'b1001, 3'h0, 16'($urandom)});
		wt(2);
		chk(code, dac);
		k = 8'($urandom);
		if (k == 8'h95)
			k = 8'h00;
		bus(1, 3'h0, k, q);
		wt(1);
		chk(unl, 0);
		dac = 16'($urandom);
		link.send({4'b1001, 3'h0, dac});
		#1;
		chk(ack, 1);
		wt(1);
		chk(code, dac);
		for (int i = 0; i < 9; i++)
		begin
			link.send({1'b0, i[0], ~i[0], 1'b0, 3'h4, 16'($urandom)});
			wt(2);
			chk(err, i == 8);
		end
		chk(code, ecode(1, 0, lo, dac));
		@(posedge clk);
		band <= 1'b1;
		wt(4);
		chk(code, ecode(1, 1, lo, dac));
		dac = 16'($urandom);
		link.send({4'b1001, 3'h0, dac});
		wt(2);
		chk(err, 0);
		chk(code, dac);
		bus(1, 3'h0, 8'h95, q);
		bus(1, 3'h2, 8'h0f, q);
		link.send({4'b1000, 3'h3, 16'h0005});
		#1;
		chk(ack, 0);
		bus(0, 3'h3, 8'h00, q);
		chk(q, 32'h05);
		loop_f <= 1'b1;
		wt(4);
		chk(err, 1);
		bus(1, 3'h2, 8'h0e, q);
		wt(2);
		chk(err, 0);
		@(posedge clk);
		loop_f <= 1'b0;
		bus(1, 3'h1, 8'h01, q);
		wt(4);
		for (int i = 0; i < 6; i++)
		begin
			bus(0, i[2:0], 8'h00, q);
			chk(q, {24'h0, rv[i]});
		end
		chk(err, 1);
		dac = 16'($urandom);
		link.send({4'b1001, 3'h0, dac});
		wt(2);
		chk(code, dac);
		link.pulse_inactive();
		wt(2);
		chk(err, 1);
		chk(code, ecode(1, 1, 8'h24, dac));
		bus(1, 3'h0, 8'h95, q);
		bus(1, 3'h2, 8'h1d, q);
		bus(1, 3'h1, 8'h10, q);
		link.pulse_inactive();
		wt(2);
		chk(err, 0);
		finish_test();
	end

endmodule : ldc_regs_tb
